/* logic/scci_card_if.sv */
module scci_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic flush,
    // fill side
    input wire logic inVal,
    output logic inRdy,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outVal,
    input wire logic outRdy,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr, rdPtr;
    logic [AW:0] count;
    logic push, pop;

    assign inRdy = count != (AW+1)'(DEPTH);
    assign outVal = count != '0;
    assign outData = mem[rdPtr];
    assign push = inVal & inRdy;
    assign pop = outVal & outRdy;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else if (flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push)
                wrPtr <= wrPtr + 1'b1;
            if (pop)
                rdPtr <= rdPtr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (push)
            mem[wrPtr] <= inData;
    end
endmodule // scci_fifo

module scci_card_if
    import scci_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire scci_bus_t busReq,
    output logic [7:0] regRdData,
    // card line
    input wire logic cardPresenceInput,
    input wire logic ioIn,
    output logic ioOut,
    output logic ioOe,
    output logic cardClk,
    output logic cardRst,
    output logic cardVcc,
    // interrupt
    output logic cardIrq
);
    logic softRst;
    logic [7:0] ctrl, cmd, ien, sel, etuHi, etuLo, gtHi, gtLo, wTop, wMid, wBot, txHold;
    logic [7:0] flags, pend, ev, stateByte, fifoData;
    logic txFull, locked, wtRun, wtenQ, presQ, divCnt, compPhase, parErr, repeatPend;
    logic [10:0] etuCnt, etuVal, limit;
    logic [8:0] gtCnt;
    logic [23:0] wtCnt, wtVal;
    logic [3:0] bitIdx;
    logic [7:0] shiftReg, deactCnt;
    logic [1:0] dStep;
    scci_seq_t seqState;
    scci_pwr_t pwState;
    logic present, uart, wait_timer_enable, conv, crep, powered, ccRise, etuTick, etuMid;
    logic canRun, txGo, rxGo, wtLoad, wtFire, wrTx, wrTop, rdIrq, rdRx;
    logic fifoInRdy, fifoVal, evRx, evTxEnd, evTxErr;

    function automatic logic hit(input scci_bus_t b, input logic [3:0] a);
        hit = b.addr == a;
    endfunction

    function automatic logic lineBit(input logic [7:0] sh, input logic [3:0] idx,
                                     input logic inv);
        logic b;
        b = 1'b0;
        if (idx == BIT_PAR)
            b = ^sh;
        else if (idx != 4'h0)
            b = inv ? sh[3'(4'h8 - idx)] : sh[3'(idx - 4'h1)];
        lineBit = (idx != 4'h0) & (b ^ inv);
    endfunction

    assign present = cardPresenceInput;
    assign uart = ctrl[CTRL_UART];
    assign wait_timer_enable = ctrl[CTRL_WAIT_TIMER_ENABLE];
    assign conv = ctrl[CTRL_CONV];
    assign crep = ctrl[CTRL_CREP];
    assign powered = pwState == PW_ON;
    assign wrTx = busReq.wr && hit(busReq, REG_TX);
    assign wrTop = busReq.wr && hit(busReq, REG_WT_TOP);
    assign rdIrq = busReq.rd && hit(busReq, REG_IRQ);
    assign rdRx = busReq.rd && hit(busReq, REG_RX);

    // card clock and bit timing
    assign ccRise = powered & ~cardClk & (divCnt | ~sel[SEL_DIV]);
    assign etuVal = {etuHi[2:0], etuLo};
    assign limit = (etuHi[ETU_COMP] & compPhase) ? etuVal - 11'h002 : etuVal - 11'h001;
    assign etuTick = ccRise & (etuCnt >= limit);
    assign etuMid = ccRise & (etuCnt == (limit >> 1));

    // sequencing decisions
    assign canRun = uart & ~locked & powered & (seqState == SQ_IDLE);
    assign txGo = canRun & (txFull | repeatPend) & (gtCnt >= {gtHi[0], gtLo}) & etuTick;
    assign rxGo = canRun & ~txGo & ~ioIn & ~ioOe & fifoInRdy;
    assign wtVal = {wTop, wMid, wBot};
    assign wtLoad = wrTop & ~wait_timer_enable;
    assign wtFire = etuTick & wtRun & ~locked & (wtCnt <= 24'h000001);
    assign evRx = (seqState == SQ_RX) & etuTick & (bitIdx == BIT_ERR) & ~parErr;
    assign evTxEnd = (seqState == SQ_TX) & etuTick & (bitIdx == BIT_ERR);
    assign evTxErr = evTxEnd & ~ioIn;

    always_comb begin
        ev = 8'h00;
        ev[IRQ_RX] = evRx;
        ev[IRQ_TX] = evTxEnd & ioIn;
        ev[IRQ_PAR] = evTxErr | ((seqState == SQ_RX) & etuTick & (bitIdx == BIT_ERR) & parErr);
        ev[IRQ_WT] = wtFire;
        ev[IRQ_CARD] = present ^ presQ;
    end

    always_comb begin
        stateByte = 8'h00;
        stateByte[ST_TXE] = ~txFull;
        stateByte[ST_BUSY] = seqState != SQ_IDLE;
        stateByte[ST_LOCK] = locked;
        stateByte[ST_RXA] = fifoVal;
        stateByte[ST_PWR] = powered;
        stateByte[ST_PRES] = present;
    end

    // receive holding path
    scci_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxFifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(softRst),
        .inVal(evRx),
        .inRdy(fifoInRdy),
        .inData(shiftReg),
        .outVal(fifoVal),
        .outRdy(rdRx),
        .outData(fifoData)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            softRst <= 1'b0;
        else
            softRst <= busReq.wr && hit(busReq, REG_CTRL) && busReq.wdata[CTRL_RST];
    end

    // register writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n || softRst) begin
            ctrl <= CTRL_INIT;
            cmd <= CMD_INIT;
            ien <= IEN_INIT;
            sel <= SEL_INIT;
            etuHi <= ETU_HI_INIT;
            etuLo <= ETU_LO_INIT;
            gtHi <= GT_HI_INIT;
            gtLo <= GT_LO_INIT;
            wTop <= WT_TOP_INIT;
            wMid <= WT_MID_INIT;
            wBot <= WT_BOT_INIT;
            txHold <= 8'h00;
            txFull <= 1'b0;
        end else begin
            if (busReq.wr) begin
                case (busReq.addr)
                    REG_CTRL: ctrl <= {1'b0, busReq.wdata[6:0]};
                    REG_CMD: cmd <= busReq.wdata;
                    REG_IEN: ien <= busReq.wdata;
                    REG_SEL: sel <= busReq.wdata;
                    REG_TX: txHold <= busReq.wdata;
                    REG_ETU_HI: etuHi <= busReq.wdata;
                    REG_ETU_LO: etuLo <= busReq.wdata;
                    REG_GT_HI: gtHi <= busReq.wdata;
                    REG_GT_LO: gtLo <= busReq.wdata;
                    REG_WT_TOP: wTop <= busReq.wdata;
                    REG_WT_MID: wMid <= busReq.wdata;
                    REG_WT_BOT: wBot <= busReq.wdata;
                    default: ;
                endcase
            end
            if (powered && !present)
                cmd[CMD_ON] <= 1'b0;
            txFull <= wrTx | (txFull & ~(txGo & ~repeatPend));
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (busReq.rd) begin
            case (busReq.addr)
                REG_CTRL: regRdData <= ctrl;
                REG_CMD: regRdData <= cmd;
                REG_STATE: regRdData <= stateByte;
                REG_IRQ: regRdData <= flags;
                REG_IEN: regRdData <= ien;
                REG_SEL: regRdData <= sel;
                REG_RX: regRdData <= fifoVal ? fifoData : 8'h00;
                REG_ETU_HI: regRdData <= etuHi;
                REG_ETU_LO: regRdData <= etuLo;
                REG_GT_HI: regRdData <= gtHi;
                REG_GT_LO: regRdData <= gtLo;
                REG_WT_TOP: regRdData <= wTop;
                REG_WT_MID: regRdData <= wMid;
                REG_WT_BOT: regRdData <= wBot;
                default: regRdData <= 8'h00;
            endcase
        end
    end

    // card clock divider
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n || softRst) begin
            divCnt <= 1'b0;
            cardClk <= 1'b0;
        end else begin
            divCnt <= ~divCnt;
            if (!powered)
                cardClk <= 1'b0;
            else if (divCnt || !sel[SEL_DIV])
                cardClk <= ~cardClk;
        end
    end

    // elementary time unit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n || softRst) begin
            etuCnt <= 11'h000;
            compPhase <= 1'b0;
        end else if (rxGo) begin
            etuCnt <= 11'h000;
        end else if (etuTick) begin
            etuCnt <= 11'h000;
            compPhase <= ~compPhase;
        end else if (ccRise) begin
            etuCnt <= etuCnt + 11'h001;
        end
    end

    // guard time
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n || softRst)
            gtCnt <= GT_INIT;
        else if (txGo)
            gtCnt <= 9'h000;
        else if (etuTick && gtCnt != GT_INIT)
            gtCnt <= gtCnt + 9'h001;
    end

    // waiting time
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n || softRst) begin
            wtCnt <= {WT_TOP_INIT, WT_MID_INIT, WT_BOT_INIT};
            wtRun <= 1'b0;
            locked <= 1'b0;
            wtenQ <= 1'b0;
        end else begin
            wtenQ <= wait_timer_enable;
            if (wtLoad) begin
                wtCnt <= wtVal;
                locked <= 1'b0;
            end else if (wtFire) begin
                wtCnt <= 24'h000000;
                wtRun <= 1'b0;
                locked <= 1'b1;
            end else if (uart && wait_timer_enable && (txGo || rxGo)) begin
                wtCnt <= wtVal;
                wtRun <= 1'b1;
            end else if (etuTick && wtRun && !locked) begin
                wtCnt <= wtCnt - 24'h000001;
            end
            if (wait_timer_enable && !wtenQ && !locked)
                wtRun <= 1'b1;
            else if (!wait_timer_enable && wtenQ)
                wtRun <= 1'b0;
        end
    end

    // character sequencer and io line
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n || softRst) begin
            seqState <= SQ_IDLE;
            bitIdx <= 4'h0;
            shiftReg <= 8'h00;
            parErr <= 1'b0;
            repeatPend <= 1'b0;
            ioOut <= 1'b0;
            ioOe <= 1'b0;
        end else if (!powered) begin
            seqState <= SQ_IDLE;
            ioOut <= 1'b0;
            ioOe <= pwState == PW_DEACT;
        end else if (!uart) begin
            seqState <= SQ_IDLE;
            ioOut <= cmd[CMD_IO];
            ioOe <= cmd[CMD_IOE];
        end else if (locked) begin
            seqState <= SQ_IDLE;
            ioOe <= 1'b0;
        end else begin
            case (seqState)
                SQ_IDLE: begin
                    ioOe <= 1'b0;
                    if (txGo) begin
                        seqState <= SQ_TX;
                        bitIdx <= 4'h0;
                        if (!repeatPend)
                            shiftReg <= txHold;
                        repeatPend <= 1'b0;
                        ioOut <= 1'b0;
                        ioOe <= 1'b1;
                    end else if (rxGo) begin
                        seqState <= SQ_RX;
                        bitIdx <= 4'h0;
                        parErr <= 1'b0;
                    end
                end
                SQ_TX: begin
                    if (etuTick) begin
                        bitIdx <= bitIdx + 4'h1;
                        if (bitIdx < BIT_PAR)
                            ioOut <= lineBit(shiftReg, bitIdx + 4'h1, conv);
                        else
                            ioOe <= 1'b0;
                        if (bitIdx == BIT_ERR) begin
                            seqState <= SQ_IDLE;
                            repeatPend <= evTxErr & crep;
                        end
                    end
                end
                SQ_RX: begin
                    if (etuMid) begin
                        if (bitIdx == 4'h0 && ioIn)
                            seqState <= SQ_IDLE;
                        else if (bitIdx != 4'h0 && bitIdx < BIT_PAR)
                            shiftReg <= conv ? {shiftReg[6:0], ~ioIn} : {ioIn, shiftReg[7:1]};
                        else if (bitIdx == BIT_PAR)
                            parErr <= (ioIn ^ conv) != ^shiftReg;
                    end
                    if (etuTick) begin
                        bitIdx <= bitIdx + 4'h1;
                        if (bitIdx == BIT_PAR && parErr && crep) begin
                            ioOut <= 1'b0;
                            ioOe <= 1'b1;
                        end else if (bitIdx == BIT_ERR) begin
                            ioOe <= 1'b0;
                            seqState <= SQ_IDLE;
                        end
                    end
                end
                default: seqState <= SQ_IDLE;
            endcase
        end
    end

    // power sequencing
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n || softRst) begin
            pwState <= PW_OFF;
            cardVcc <= 1'b0;
            cardRst <= 1'b0;
            deactCnt <= 8'h00;
            dStep <= 2'h0;
            presQ <= 1'b0;
        end else begin
            presQ <= present;
            case (pwState)
                PW_OFF: begin
                    cardRst <= 1'b0;
                    if (cmd[CMD_ON] && present) begin
                        pwState <= PW_ON;
                        cardVcc <= 1'b1;
                    end
                end
                PW_ON: begin
                    cardRst <= cmd[CMD_RST];
                    if (!present || !cmd[CMD_ON]) begin
                        pwState <= PW_DEACT;
                        cardRst <= 1'b0;
                        deactCnt <= 8'h00;
                        dStep <= 2'h0;
                    end
                end
                PW_DEACT: begin
                    deactCnt <= deactCnt + 8'h01;
                    if (deactCnt == DEACT_CYCLES) begin
                        deactCnt <= 8'h00;
                        dStep <= dStep + 2'h1;
                        if (dStep == 2'h2) begin
                            pwState <= PW_OFF;
                            cardVcc <= 1'b0;
                        end
                    end
                end
                default: pwState <= PW_OFF;
            endcase
        end
    end

    // interrupt flags, deferred over a flag read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n || softRst) begin
            flags <= 8'h00;
            pend <= 8'h00;
            cardIrq <= 1'b0;
        end else if (rdIrq) begin
            flags <= 8'h00;
            pend <= pend | ev;
            cardIrq <= 1'b0;
        end else begin
            flags <= flags | pend | ev;
            pend <= 8'h00;
            cardIrq <= |((flags | pend | ev) & ien);
        end
    end

    a_wt_lock: assert property (@(posedge mclk) disable iff (!rst_n)
        wtFire && !softRst |=> locked && !wtRun) else $error("timeout did not lock");
    a_wt_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wtLoad && !softRst |=> wtCnt == $past(wtVal)) else $error("wait load missed");
    a_irq_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        rdIrq |=> !cardIrq && flags == 8'h00) else $error("flag read did not clear");
    a_irq_defer: assert property (@(posedge mclk) disable iff (!rst_n)
        rdIrq && ev != 8'h00 && !softRst ##1 !rdIrq && !softRst |-> flags == 8'h00
        ##1 (flags & $past(ev, 2)) == $past(ev, 2)) else $error("deferred flag lost");
    a_pw_refuse: assert property (@(posedge mclk) disable iff (!rst_n)
        pwState == PW_OFF && !present |=> pwState == PW_OFF) else $error("power without card");
    a_remove_deact: assert property (@(posedge mclk) disable iff (!rst_n)
        powered && !present && !softRst |=> pwState == PW_DEACT && !cardRst)
        else $error("removal not deactivated");
    a_tx_keep: assert property (@(posedge mclk) disable iff (!rst_n)
        seqState == SQ_TX && !softRst |=> $stable(shiftReg)) else $error("shifter changed");
    a_guard_gap: assert property (@(posedge mclk) disable iff (!rst_n)
        txGo && !softRst |=> gtCnt == 9'h000 && seqState == SQ_TX) else $error("guard restart");
    a_manual_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        !uart && powered |=> seqState == SQ_IDLE) else $error("sequencer ran in manual");
endmodule // scci_card_if

/* logic/scci_pkg.sv */
package scci_pkg;
    // register indices, low byte at higher index
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CMD = 4'h1;
    localparam logic [3:0] REG_STATE = 4'h2;
    localparam logic [3:0] REG_IRQ = 4'h3;
    localparam logic [3:0] REG_IEN = 4'h4;
    localparam logic [3:0] REG_SEL = 4'h5;
    localparam logic [3:0] REG_TX = 4'h6;
    localparam logic [3:0] REG_RX = 4'h7;
    localparam logic [3:0] REG_ETU_HI = 4'h8;
    localparam logic [3:0] REG_ETU_LO = 4'h9;
    localparam logic [3:0] REG_GT_HI = 4'ha;
    localparam logic [3:0] REG_GT_LO = 4'hb;
    localparam logic [3:0] REG_WT_TOP = 4'hc;
    localparam logic [3:0] REG_WT_MID = 4'hd;
    localparam logic [3:0] REG_WT_BOT = 4'he;
    // field positions
    localparam int CTRL_RST = 7;
    localparam int CTRL_UART = 3;
    localparam int CTRL_WAIT_TIMER_ENABLE = 2;
    localparam int CTRL_CREP = 1;
    localparam int CTRL_CONV = 0;
    localparam int CMD_ON = 0;
    localparam int CMD_RST = 1;
    localparam int CMD_IO = 2;
    localparam int CMD_IOE = 3;
    localparam int ST_TXE = 7;
    localparam int ST_BUSY = 4;
    localparam int ST_LOCK = 3;
    localparam int ST_RXA = 2;
    localparam int ST_PWR = 1;
    localparam int ST_PRES = 0;
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_PAR = 2;
    localparam int IRQ_WT = 3;
    localparam int IRQ_CARD = 4;
    localparam int SEL_DIV = 3;
    localparam int ETU_COMP = 7;
    // reset values
    localparam logic [7:0] CTRL_INIT = 8'h00;
    localparam logic [7:0] CMD_INIT = 8'h00;
    localparam logic [7:0] IEN_INIT = 8'h00;
    localparam logic [7:0] SEL_INIT = 8'h08;
    localparam logic [7:0] ETU_HI_INIT = 8'h01;
    localparam logic [7:0] ETU_LO_INIT = 8'h74;
    localparam logic [7:0] GT_HI_INIT = 8'h00;
    localparam logic [7:0] GT_LO_INIT = 8'h0c;
    localparam logic [7:0] WT_TOP_INIT = 8'h00;
    localparam logic [7:0] WT_MID_INIT = 8'h25;
    localparam logic [7:0] WT_BOT_INIT = 8'h80;
    localparam logic [8:0] GT_INIT = 9'h1ff;
    // character timing, deactivation step length and sizes
    localparam logic [3:0] BIT_PAR = 4'h9;
    localparam logic [3:0] BIT_ERR = 4'ha;
    localparam logic [7:0] DEACT_CYCLES = 8'h10;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } scci_bus_t;

    typedef enum logic [1:0] {SQ_IDLE, SQ_TX, SQ_RX} scci_seq_t;
    typedef enum logic [1:0] {PW_OFF, PW_ON, PW_DEACT} scci_pwr_t;
endpackage

/* test/scci_card_model.sv */
module scci_card_model (
    // io line
    input wire logic ioOe,
    input wire logic ioOut,
    output logic ioIn,
    // presence switch
    input wire logic inserted,
    output logic presence
);
    timeunit 1ns;
    timeprecision 1ps;
    assign presence = inserted;
    // pulled-up line, card stays idle
    assign ioIn = ioOe ? ioOut : 1'b1;
endmodule // scci_card_model

/* test/smart_card_character_interface_tb.sv */
module smart_card_character_interface_tb import scci_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic inserted = 1'b0;
    scci_bus_t busReq = '0;
    logic [7:0] regRdData, lfsr = 8'h03, mdl [16];
    logic presence, ioIn, ioOut, ioOe, cardClk, cardRst, cardVcc, cardIrq;
    int fails = 0;
    int check_count = 0;
    always #12.5 mclk = ~mclk;
    scci_card_if dut_u (.mclk(mclk), .rst_n(rst_n), .busReq(busReq), .regRdData(regRdData),
        .cardPresenceInput(presence), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
        .cardClk(cardClk), .cardRst(cardRst), .cardVcc(cardVcc), .cardIrq(cardIrq));
    scci_card_model card_u (.ioOe(ioOe), .ioOut(ioOut), .ioIn(ioIn), .inserted(inserted),
        .presence(presence));
    function automatic logic [7:0] nxt(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic cmp(string what, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
        @(posedge mclk);
        #2;
        busReq = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge mclk);
        #2;
        busReq.wr = 1'b0;
        busReq.rd = 1'b0;
    endtask
    task automatic chk(logic [3:0] a);
        bus(1'b0, a, 8'h00);
        cmp($sformatf("reg %h", a), mdl[a], regRdData);
    endtask
    task automatic chkAll();
        for (int i = 0; i < 16; i++) begin
            if (i != 6) chk(4'(i));
        end
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #50000;
        fails++;
        conclude();
    end
    initial begin
        mdl = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h01, 8'h74,
            8'h00, 8'h0c, 8'h00, 8'h25, 8'h80, 8'h00};
        repeat (5) @(posedge mclk);
        #2;
        rst_n = 1'b1;
        chkAll();
        for (int i = 0; i < 3; i++) begin
            lfsr = nxt(lfsr);
            bus(1'b1, REG_WT_BOT, lfsr);
            bus(1'b1, REG_GT_LO, ~lfsr);
            bus(1'b1, REG_STATE, lfsr);
            bus(1'b1, 4'hf, lfsr);
            mdl[14] = lfsr;
            mdl[11] = ~lfsr;
            chk(REG_WT_BOT);
            chk(REG_GT_LO);
            chk(REG_STATE);
            chk(4'hf);
        end
        bus(1'b1, REG_CMD, 8'h01);
        repeat (60) @(posedge mclk);
        #2;
        cmp("vcc", 8'h00, {7'h0, cardVcc});
        bus(1'b1, REG_IEN, 8'h10);
        inserted = 1'b1;
        repeat (6) @(posedge mclk);
        #2;
        cmp("irq", 8'h01, {7'h0, cardIrq});
        mdl[3] = 8'h10;
        chk(REG_IRQ);
        #30;
        cmp("irq", 8'h00, {7'h0, cardIrq});
        bus(1'b1, REG_CMD, 8'h01);
        repeat (60) @(posedge mclk);
        #2;
        cmp("vcc", 8'h01, {7'h0, cardVcc});
        inserted = 1'b0;
        repeat (60) @(posedge mclk);
        #2;
        cmp("vcc", 8'h00, {7'h0, cardVcc});
        cmp("clk", 8'h00, {7'h0, cardClk});
        bus(1'b1, REG_CTRL, 8'h80);
        mdl = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h01, 8'h74,
            8'h00, 8'h0c, 8'h00, 8'h25, 8'h80, 8'h00};
        chkAll();
        bus(1'b1, REG_CTRL, 8'h08);
        bus(1'b1, REG_SEL, 8'h00);
        bus(1'b1, REG_ETU_HI, 8'h00);
        bus(1'b1, REG_ETU_LO, 8'h04);
        inserted = 1'b1;
        bus(1'b1, REG_CMD, 8'h01);
        lfsr = nxt(lfsr);
        bus(1'b1, REG_TX, lfsr);
        @(posedge mclk iff ioOe);
        repeat (3) @(posedge mclk);
        #2;
        for (int k = 0; k < 10; k++) begin
            cmp($sformatf("io bit %0d", k),
                {7'h0, (k == 9) ? ^lfsr : ((k == 0) ? 1'b0 : lfsr[k - 1])}, {7'h0, ioOut});
            repeat (8) @(posedge mclk);
            #2;
        end
        cmp("io drive", 8'h00, {7'h0, ioOe});
        repeat (8) @(posedge mclk);
        mdl[3] = 8'h12;
        chk(REG_IRQ);
        bus(1'b1, REG_WT_BOT, 8'h02);
        bus(1'b1, REG_WT_MID, 8'h00);
        bus(1'b1, REG_WT_TOP, 8'h00);
        bus(1'b1, REG_CTRL, 8'h0c);
        repeat (40) @(posedge mclk);
        mdl[2] = 8'h8b;
        chk(REG_STATE);
        bus(1'b1, REG_CTRL, 8'h08);
        bus(1'b1, REG_WT_TOP, 8'h00);
        bus(1'b1, REG_CTRL, 8'h0c);
        mdl[2] = 8'h83;
        chk(REG_STATE);
        conclude();
    end
endmodule // smart_card_character_interface_tb
